// >>> line_side_regs.svh
// Notes on behaviour
// - Validation off: fullwave bit picks half/full-wave detect.
// - Validation on: bit picks envelope or one-shot.
// - Live overload flag self-clears when overload ends.
// - Live overload masked by off-hook counter only.
// - Dropout flag set when supply collapses off-hook.
// - Overcurrent flag set above configured trip threshold.
// - Receive monitor gain is field over 64.
// - Receive gain zero mutes receive contribution.
// - Transmit monitor gain is field over 64.
// - Transmit gain zero mutes transmit contribution.
// - Ring control bits 7:2 read as zero.
// - Sticky overload set below ground, write-zero clears.
`ifndef LINE_SIDE_REGS_SVH
`define LINE_SIDE_REGS_SVH

// Register indices; byte address is four times the index.
`define RING_CFG_IDX 6'h12
`define LINE_FAULT_IDX 6'h13
`define RX_GAIN_IDX 6'h14
`define TX_GAIN_IDX 6'h15
`define LINE_CTRL_IDX 6'h20
`define OVERLOAD_IDX 6'h21
`define IRQ_STATUS_IDX 6'h22
`define IRQ_MASK_IDX 6'h23

// Field positions.
`define RING_FULLWAVE_BIT 1
`define VALIDATION_EN_BIT 0
`define BILLING_EN_BIT 1
`define OVERLOAD_STICKY_BIT 0
`define FAULT_OVERLOAD_BIT 2
`define FAULT_DROPOUT_BIT 1
`define FAULT_OVERCURRENT_BIT 0

// Reset value and unity gain code.
`define REG_RESET_VAL 8'h00
`define UNITY_GAIN 8'h40

// Gain is field/64, so the product drops six fraction bits.
`define GAIN_FRAC_BITS 6

// One-shot length in clock cycles (default of the top parameter).
`define ONE_SHOT_CYCLES_DFLT 1024

`endif

// >>> line_side_pkg.sv
package line_side_pkg;

    // Width of the call progress audio samples.
    parameter int SAMPLE_W = 16;

    // Line pins, carried together through the synchroniser.
    typedef struct packed {
        logic rxBelowGround;
        logic supplyCollapse;
        logic loopOverTrip;
        logic offHook;
        logic offHookMaskActive;
        logic ringPosCross;
        logic ringNegCross;
        logic ringValidEnv;
    } line_pins_t;

    // Live fault flags as they appear in the fault status register.
    typedef struct packed {
        logic overloadLive;
        logic supplyDropoutFlag;
        logic overcurrentFlag;
    } fault_flags_t;

    // AXI response codes.
    typedef enum logic [1:0] {
        RESP_OKAY = 2'b00,
        RESP_SLVERR = 2'b10
    } axi_resp_t;

    // States of the ring one-shot.
    typedef enum logic [0:0] {
        SHOT_IDLE = 1'b0,
        SHOT_ACTIVE = 1'b1
    } shot_state_t;

    // Saturates a wide signed value into one audio sample.
    function automatic logic signed [SAMPLE_W-1:0] satSample(
        input logic signed [31:0] v);
        logic signed [31:0] hi;
        logic signed [31:0] lo;
        hi = 32'sd2 ** (SAMPLE_W - 1) - 32'sd1;
        lo = -(32'sd2 ** (SAMPLE_W - 1));
        if (v > hi) begin
            satSample = hi[SAMPLE_W-1:0];
        end else if (v < lo) begin
            satSample = lo[SAMPLE_W-1:0];
        end else begin
            satSample = v[SAMPLE_W-1:0];
        end
    endfunction

endpackage

// >>> ring_detect_sel.sv
`timescale 1ns/1ps
`include "line_side_regs.svh"

module ring_detect_sel
    import line_side_pkg::*;
#(
    parameter int ONE_SHOT_CYCLES = `ONE_SHOT_CYCLES_DFLT
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic ringValidationEnable,
    input wire logic ringFullwaveSelect,
    input wire logic ringPosCross,
    input wire logic ringNegCross,
    input wire logic ringValidEnv,
    output logic ringOut
);

    localparam int CNT_W = $clog2(ONE_SHOT_CYCLES + 1);

    shot_state_t shot_q; // One-shot state.
    logic [CNT_W-1:0] shotCnt_q; // Cycles left in the one-shot.
    logic cross_q; // Previous crossing level, for the rising edge.
    logic crossing; // Threshold crossing for the current mode.
    logic crossRise; // Start of a new crossing.

    // Full-wave counts both polarities, half-wave only the positive one.
    assign crossing = ringPosCross | (ringFullwaveSelect & ringNegCross);
    assign crossRise = crossing & ~cross_q;

    // Edge memory for the one-shot trigger.
    always_ff @(posedge clk) begin
        if (reset) begin
            cross_q <= 1'b0;
        end else begin
            cross_q <= crossing;
        end
    end

    // The one-shot is unqualified: it ends on the counter, not the ring.
    always_ff @(posedge clk) begin
        if (reset) begin
            shot_q <= SHOT_IDLE;
            shotCnt_q <= '0;
        end else begin
            case (shot_q)
                SHOT_IDLE: begin
                    if (crossRise) begin
                        shot_q <= SHOT_ACTIVE;
                        shotCnt_q <= CNT_W'(ONE_SHOT_CYCLES - 1);
                    end
                end
                SHOT_ACTIVE: begin
                    if (shotCnt_q == '0) begin
                        shot_q <= SHOT_IDLE;
                    end else begin
                        shotCnt_q <= shotCnt_q - 1'b1;
                    end
                end
                default: begin
                    shot_q <= SHOT_IDLE;
                end
            endcase
        end
    end

    // Output selection; registered so the top output is a flop.
    always_ff @(posedge clk) begin
        if (reset) begin
            ringOut <= 1'b0;
        end else if (!ringValidationEnable) begin
            ringOut <= crossing;
        end else if (ringFullwaveSelect) begin
            ringOut <= (shot_q == SHOT_ACTIVE);
        end else begin
            ringOut <= ringValidEnv;
        end
    end

    a_halfwave_mode: assert property (@(posedge clk) disable iff (reset)
        !ringValidationEnable && !ringFullwaveSelect && ringNegCross
        && !ringPosCross |=> !ringOut)
        else $error("Half-wave mode reacted to a negative crossing.");

    a_envelope_follow: assert property (@(posedge clk)
        disable iff (reset)
        ringValidationEnable && !ringFullwaveSelect
        |=> ringOut == $past(ringValidEnv))
        else $error("Ring output did not follow the validated envelope.");

    a_oneshot_start: assert property (@(posedge clk) disable iff (reset)
        shot_q == SHOT_IDLE && crossRise |=> shot_q == SHOT_ACTIVE
        ##1 (shot_q == SHOT_ACTIVE))
        else $error("Ring one-shot did not start on a crossing.");

endmodule // ring_detect_sel

// >>> monitor_gain.sv
`timescale 1ns/1ps
`include "line_side_regs.svh"

module monitor_gain
    import line_side_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [7:0] gain,
    input wire logic sampleValid,
    input wire logic signed [SAMPLE_W-1:0] sampleIn,
    output logic signed [SAMPLE_W-1:0] sampleOut
);

    logic signed [31:0] product; // Sample times the gain code.
    logic signed [31:0] scaled; // Product divided by 64.

    // Linear gain; codes above 0x40 amplify, so the result saturates.
    always_comb begin
        product = 32'(sampleIn) * $signed({24'h000000, gain});
        scaled = product >>> `GAIN_FRAC_BITS;
    end

    // A zero code is forced to silence rather than trusting rounding.
    always_ff @(posedge clk) begin
        if (reset) begin
            sampleOut <= '0;
        end else if (sampleValid) begin
            if (gain == 8'h00) begin
                sampleOut <= '0;
            end else begin
                sampleOut <= satSample(scaled);
            end
        end
    end

    a_zero_mutes: assert property (@(posedge clk) disable iff (reset)
        sampleValid && gain == 8'h00 |=> sampleOut == '0)
        else $error("Zero gain code did not mute the path.");

    a_unity_gain: assert property (@(posedge clk) disable iff (reset)
        sampleValid && gain == `UNITY_GAIN |=> sampleOut == $past(sampleIn))
        else $error("Unity gain code changed the sample.");

endmodule // monitor_gain

// >>> line_side_ctrl_status_regs.sv
`timescale 1ns/1ps
`include "line_side_regs.svh"

module line_side_ctrl_status_regs
    import line_side_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter int ONE_SHOT_CYCLES = `ONE_SHOT_CYCLES_DFLT
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire line_pins_t linePins,
    input wire logic sampleValid,
    input wire logic signed [SAMPLE_W-1:0] rxSample,
    input wire logic signed [SAMPLE_W-1:0] txSample,
    output logic ringDetectOut,
    output logic signed [SAMPLE_W-1:0] callProgressOut,
    output logic irq
);

    line_pins_t pinMeta_q; // First synchroniser stage, read by stage two.
    line_pins_t pinSync_q; // Pins safe to use in this domain.
    fault_flags_t fault_q; // Live fault flags.
    fault_flags_t faultPrev_q; // Flags one cycle ago, for edge events.
    logic ringPrev_q; // Previous ring output, for the ring event.
    logic ringFullwaveSelect_q; // Ring detector mode bit.
    logic ringValidationEnable_q; // Selects the validated ring path.
    logic billingToneDetectEn_q; // Billing tone enable; no live effect.
    logic rxOverloadSticky_q; // Sticky receive overload.
    logic [7:0] rxMonitorGain_q; // Receive monitor gain code.
    logic [7:0] txMonitorGain_q; // Transmit monitor gain code.
    logic [3:0] irqStatus_q; // Sticky event bits; bit 0 is overload.
    logic [3:0] irqMask_q; // Enables for the event bits.
    logic [3:0] irqEvent; // Events raised this cycle.
    logic awHeld_q; // Write address accepted, waiting.
    logic wHeld_q; // Write data accepted, waiting.
    logic [5:0] awIdx_q; // Held write register index.
    logic [7:0] wByte_q; // Held write data, byte lane 0.
    logic wLane0_q; // Lane 0 strobe of the held data.
    logic awHeld_d;
    logic wHeld_d;
    logic rvalid_d;
    logic wrFire; // A complete write is performed this cycle.
    logic rdFire; // A read address is taken this cycle.
    logic wrLane; // Register contents change on this write.
    logic signed [SAMPLE_W-1:0] rxScaled; // Scaled receive contribution.
    logic signed [SAMPLE_W-1:0] txScaled; // Scaled transmit contribution.
    logic ringOut; // Selected ring detect level.

    // Register index from a byte address; low address bits are ignored.
    function automatic logic [5:0] regIndex(input logic [ADDR_W-1:0] a);
        regIndex = a[7:2];
    endfunction

    // True for an index that maps to a register.
    function automatic logic isMapped(input logic [5:0] idx);
        case (idx)
            `RING_CFG_IDX, `LINE_FAULT_IDX, `RX_GAIN_IDX, `TX_GAIN_IDX,
            `LINE_CTRL_IDX, `OVERLOAD_IDX, `IRQ_STATUS_IDX,
            `IRQ_MASK_IDX: isMapped = 1'b1;
            default: isMapped = 1'b0;
        endcase
    endfunction

    // Two-stage synchroniser for every line pin.
    always_ff @(posedge clk) begin
        if (reset) begin
            pinMeta_q <= '0;
            pinSync_q <= '0;
        end else begin
            pinMeta_q <= linePins;
            pinSync_q <= pinMeta_q;
        end
    end

    // Live flags follow their cause and clear with it.
    always_ff @(posedge clk) begin
        if (reset) begin
            fault_q <= '0;
            faultPrev_q <= '0;
        end else begin
            // Only the off-hook counter hides overload; billing is ignored.
            fault_q.overloadLive <= pinSync_q.rxBelowGround
                & ~pinSync_q.offHookMaskActive;
            fault_q.supplyDropoutFlag <= pinSync_q.supplyCollapse
                & pinSync_q.offHook;
            // The trip level itself is set up outside this block.
            fault_q.overcurrentFlag <= pinSync_q.loopOverTrip;
            faultPrev_q <= fault_q;
        end
    end

    // Ring detect selection and its one-shot.
    ring_detect_sel #(
        .ONE_SHOT_CYCLES(ONE_SHOT_CYCLES)
    ) ringSel (
        .clk(clk),
        .reset(reset),
        .ringValidationEnable(ringValidationEnable_q),
        .ringFullwaveSelect(ringFullwaveSelect_q),
        .ringPosCross(pinSync_q.ringPosCross),
        .ringNegCross(pinSync_q.ringNegCross),
        .ringValidEnv(pinSync_q.ringValidEnv),
        .ringOut(ringOut)
    );

    assign ringDetectOut = ringOut;

    // Per-path gain stages for the call progress monitor.
    monitor_gain rxGain (
        .clk(clk),
        .reset(reset),
        .gain(rxMonitorGain_q),
        .sampleValid(sampleValid),
        .sampleIn(rxSample),
        .sampleOut(rxScaled)
    );

    monitor_gain txGain (
        .clk(clk),
        .reset(reset),
        .gain(txMonitorGain_q),
        .sampleValid(sampleValid),
        .sampleIn(txSample),
        .sampleOut(txScaled)
    );

    // Mix both paths; saturation avoids wrap-around clicks on loud tones.
    always_ff @(posedge clk) begin
        if (reset) begin
            callProgressOut <= '0;
        end else begin
            callProgressOut <= satSample(32'(rxScaled) + 32'(txScaled));
        end
    end

    // Write channel handshakes: address and data may come in any order.
    always_comb begin
        wrFire = awHeld_q & wHeld_q & ~s_axi_bvalid;
        awHeld_d = awHeld_q;
        wHeld_d = wHeld_q;
        if (wrFire) begin
            awHeld_d = 1'b0;
            wHeld_d = 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_d = 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_d = 1'b1;
            end
        end
        wrLane = wrFire & wLane0_q & isMapped(awIdx_q);
    end

    // Write channel state and the write response.
    always_ff @(posedge clk) begin
        if (reset) begin
            awHeld_q <= 1'b0;
            wHeld_q <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            awIdx_q <= '0;
            wByte_q <= '0;
            wLane0_q <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            awHeld_q <= awHeld_d;
            wHeld_q <= wHeld_d;
            s_axi_awready <= ~awHeld_d;
            s_axi_wready <= ~wHeld_d;
            if (s_axi_awvalid && s_axi_awready) begin
                awIdx_q <= regIndex(s_axi_awaddr);
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wByte_q <= s_axi_wdata[7:0];
                wLane0_q <= s_axi_wstrb[0];
            end
            if (wrFire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= isMapped(awIdx_q) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Software-written configuration registers.
    always_ff @(posedge clk) begin
        if (reset) begin
            ringFullwaveSelect_q <= 1'b0;
            ringValidationEnable_q <= 1'b0;
            billingToneDetectEn_q <= 1'b0;
            rxMonitorGain_q <= `REG_RESET_VAL;
            txMonitorGain_q <= `REG_RESET_VAL;
            irqMask_q <= '0;
        end else if (wrLane) begin
            case (awIdx_q)
                `RING_CFG_IDX: begin
                    ringFullwaveSelect_q <= wByte_q[`RING_FULLWAVE_BIT];
                end
                `RX_GAIN_IDX: begin
                    rxMonitorGain_q <= wByte_q;
                end
                `TX_GAIN_IDX: begin
                    txMonitorGain_q <= wByte_q;
                end
                `LINE_CTRL_IDX: begin
                    ringValidationEnable_q <= wByte_q[`VALIDATION_EN_BIT];
                    billingToneDetectEn_q <= wByte_q[`BILLING_EN_BIT];
                end
                `IRQ_MASK_IDX: begin
                    irqMask_q <= wByte_q[3:0];
                end
                default: begin
                    // Read-only and status registers are handled elsewhere.
                end
            endcase
        end
    end

    // Events: overload level, and rising edges of the other indications.
    assign irqEvent = {ringOut & ~ringPrev_q,
        fault_q.overcurrentFlag & ~faultPrev_q.overcurrentFlag,
        fault_q.supplyDropoutFlag & ~faultPrev_q.supplyDropoutFlag,
        pinSync_q.rxBelowGround};

    // Sticky overload and event bits; a new event beats a clear.
    always_ff @(posedge clk) begin
        if (reset) begin
            rxOverloadSticky_q <= 1'b0;
            irqStatus_q <= '0;
            ringPrev_q <= 1'b0;
        end else begin
            ringPrev_q <= ringOut;
            if (wrLane && awIdx_q == `OVERLOAD_IDX
                && !wByte_q[`OVERLOAD_STICKY_BIT]) begin
                // Writing zero clears the sticky bit and its event bit.
                rxOverloadSticky_q <= pinSync_q.rxBelowGround;
                irqStatus_q <= irqEvent
                    | (irqStatus_q & 4'hE);
            end else if (wrLane && awIdx_q == `IRQ_STATUS_IDX) begin
                rxOverloadSticky_q <= rxOverloadSticky_q
                    | pinSync_q.rxBelowGround;
                irqStatus_q <= irqEvent | (irqStatus_q & ~wByte_q[3:0]);
            end else begin
                rxOverloadSticky_q <= rxOverloadSticky_q
                    | pinSync_q.rxBelowGround;
                irqStatus_q <= irqStatus_q | irqEvent;
            end
        end
    end

    // Level interrupt from any unmasked event bit.
    always_ff @(posedge clk) begin
        if (reset) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irqStatus_q & irqMask_q);
        end
    end

    // Read channel: one read at a time, data registered with rvalid.
    assign rdFire = s_axi_arvalid & s_axi_arready;
    assign rvalid_d = rdFire | (s_axi_rvalid & ~s_axi_rready);

    // Read data mux; reserved ring control bits read as zero.
    always_ff @(posedge clk) begin
        if (reset) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            s_axi_rvalid <= rvalid_d;
            s_axi_arready <= ~rvalid_d;
            if (rdFire) begin
                s_axi_rresp <= isMapped(regIndex(s_axi_araddr))
                    ? RESP_OKAY : RESP_SLVERR;
                case (regIndex(s_axi_araddr))
                    `RING_CFG_IDX: s_axi_rdata <=
                        {30'h0, ringFullwaveSelect_q, 1'b0};
                    `LINE_FAULT_IDX: s_axi_rdata <= {29'h0, fault_q};
                    `RX_GAIN_IDX: s_axi_rdata <= {24'h0, rxMonitorGain_q};
                    `TX_GAIN_IDX: s_axi_rdata <= {24'h0, txMonitorGain_q};
                    `LINE_CTRL_IDX: s_axi_rdata <= {30'h0,
                        billingToneDetectEn_q, ringValidationEnable_q};
                    `OVERLOAD_IDX: s_axi_rdata <= {31'h0, rxOverloadSticky_q};
                    `IRQ_STATUS_IDX: s_axi_rdata <= {28'h0, irqStatus_q};
                    `IRQ_MASK_IDX: s_axi_rdata <= {28'h0, irqMask_q};
                    default: s_axi_rdata <= 32'h0;
                endcase
            end
        end
    end

    a_overload_live: assert property (@(posedge clk) disable iff (reset)
        pinSync_q.rxBelowGround && !pinSync_q.offHookMaskActive
        |=> fault_q.overloadLive)
        else $error("Live overload flag missed an overload.");

    // The live flag must drop on its own once the cause has gone.
    a_overload_clear: assert property (@(posedge clk) disable iff (reset)
        !pinSync_q.rxBelowGround |=> !fault_q.overloadLive)
        else $error("Live overload flag did not clear by itself.");

    a_overload_mask: assert property (@(posedge clk) disable iff (reset)
        pinSync_q.offHookMaskActive |=> !fault_q.overloadLive)
        else $error("Live overload flag not masked by off-hook counter.");

    a_dropout_flag: assert property (@(posedge clk) disable iff (reset)
        1'b1 |=> fault_q.supplyDropoutFlag == $past(
        pinSync_q.supplyCollapse && pinSync_q.offHook))
        else $error("Dropout flag does not match supply and hook state.");

    a_overcurrent_flag: assert property (@(posedge clk)
        disable iff (reset)
        1'b1 |=> fault_q.overcurrentFlag == $past(pinSync_q.loopOverTrip))
        else $error("Overcurrent flag does not follow the trip input.");

    a_sticky_set: assert property (@(posedge clk) disable iff (reset)
        pinSync_q.rxBelowGround |=> rxOverloadSticky_q && irqStatus_q[0])
        else $error("Sticky overload not set by an overload.");

    a_sticky_clear: assert property (@(posedge clk) disable iff (reset)
        wrLane && awIdx_q == `OVERLOAD_IDX && !wByte_q[0]
        && !pinSync_q.rxBelowGround |=> !rxOverloadSticky_q && !irqStatus_q[0])
        else $error("Writing zero did not clear the sticky overload.");

    a_reserved_read: assert property (@(posedge clk) disable iff (reset)
        rdFire && regIndex(s_axi_araddr) == `RING_CFG_IDX
        |=> s_axi_rvalid && s_axi_rdata[31:2] == 30'h0)
        else $error("Ring control read returned nonzero reserved bits.");

endmodule // line_side_ctrl_status_regs

// >>> line_model.sv
`timescale 1ns/1ps
// Far side of the line: it applies the pin levels that the bench asks for
// one edge later, as a comparator front end would.
module line_model
    import line_side_pkg::*;
(
    input wire logic clk,
    input wire line_pins_t want,
    output line_pins_t pins
);
    // Registered so that pins never move in the bench's own time step.
    always_ff @(posedge clk) begin
        pins <= want;
    end
endmodule // line_model

// >>> test_line_side_ctrl_status_regs.sv
`timescale 1ns/1ps
module test_line_side_ctrl_status_regs
    import line_side_pkg::*;
;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] awAddr = '0, arAddr = '0;
    logic awValid = 1'b0, wValid = 1'b0, arValid = 1'b0, sv = 1'b0;
    logic [31:0] wData = '0, rData, a, seed = 32'h00000054;
    logic awReady, wReady, bValid, arReady, rValid, ring, irq;
    logic [1:0] bResp, rResp;
    logic signed [15:0] rxS = '0, txS = '0, cpo;
    line_pins_t want = '0, pins;
    logic [7:0] g1, g2, gt[4] = '{8'h00, 8'hFF, 8'h40, 8'h7F};
    logic [10:0] e, rt[6] = '{11'h004, 11'h009, 11'h405, 11'h203,
        11'h602, 11'h609};
    int errorCnt = 0, cmpCount = 0;
    line_model far (.clk(clk), .want(want), .pins(pins));
    // One-shot shortened to 8 cycles to keep the run brief.
    line_side_ctrl_status_regs #(.ONE_SHOT_CYCLES(8)) dut (.clk(clk),
        .reset(reset), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
        .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
        .s_axi_bvalid(bValid), .s_axi_bready(1'b1), .s_axi_araddr(arAddr),
        .s_axi_arvalid(arValid), .s_axi_arready(arReady),
        .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
        .s_axi_rready(1'b1), .linePins(pins), .sampleValid(sv),
        .rxSample(rxS), .txSample(txS), .ringDetectOut(ring),
        .callProgressOut(cpo), .irq(irq));
    initial begin
        forever #2.5 clk = ~clk;
    end
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic int clip(int s);
        return (s > 32767) ? 32767 : (s < -32768) ? -32768 : s;
    endfunction
    // Expected monitor sum: each path is field/64 and clipped, then the sum.
    function automatic logic [15:0] mix(logic [31:0] v, int ga, gb);
        int s;
        s = clip(($signed(v[15:0]) * ga) >>> 6)
            + clip(($signed(v[31:16]) * gb) >>> 6);
        return 16'(clip(s));
    endfunction
    task automatic report_and_stop();
        $display("compares %0d errors %0d", cmpCount, errorCnt);
        if (errorCnt == 0 && cmpCount > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [33:0] got, exp);
        cmpCount++;
        if (got !== exp) begin
            errorCnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Bounded waits end the run rather than hang it.
    task automatic tmo(int n);
        if (n >= 50) begin
            errorCnt++;
            report_and_stop();
        end
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge clk);
    endtask
    // Ready is sampled at the falling edge, so the rising edge that takes
    // the item is known before the valid is dropped right after it.
    task automatic wr(logic [7:0] ad, logic [7:0] d, logic [1:0] r);
        int n;
        logic [2:0] hs;
        logic [1:0] rs;
        n = 0;
        awAddr <= ad;
        wData <= {24'h0, d};
        awValid <= 1'b1;
        wValid <= 1'b1;
        do begin
            @(negedge clk);
            n++;
            hs = {awValid & awReady, wValid & wReady, bValid};
            rs = bResp;
            @(posedge clk);
            if (hs[2]) awValid <= 1'b0;
            if (hs[1]) wValid <= 1'b0;
        end while (!hs[0] && n < 50);
        tmo(n);
        chk(rs, r);
    endtask
    task automatic rd(logic [7:0] ad, logic [7:0] d, logic [1:0] r);
        int n;
        logic [1:0] hs;
        n = 0;
        arAddr <= ad;
        arValid <= 1'b1;
        do begin
            @(negedge clk);
            n++;
            hs = {arValid & arReady, rValid};
            @(posedge clk);
            if (hs[1]) arValid <= 1'b0;
        end while (!hs[0] && n < 50);
        tmo(n);
        chk({rResp, rData}, {r, 24'h0, d});
    endtask
    initial begin
        tick(3);
        reset <= 1'b0;
        tick(1);
        for (int i = 0; i < 4; i++) begin
            rd(8'(8'h48 + 4 * i), 8'h00, RESP_OKAY);
        end
        rd(8'hFC, 8'h00, RESP_SLVERR);
        wr(8'hF0, 8'h01, RESP_SLVERR);
        $display("register reset test done");
        for (int k = 0; k < 8; k++) begin
            g1 = (k < 4) ? gt[k] : 8'(xs());
            g2 = (k < 4) ? gt[3 - k] : 8'(xs());
            wr(8'h50, g1, RESP_OKAY);
            wr(8'h54, g2, RESP_OKAY);
            rd(8'h50, g1, RESP_OKAY);
            rd(8'h54, g2, RESP_OKAY);
            a = xs();
            rxS <= a[15:0];
            txS <= a[31:16];
            sv <= 1'b1;
            tick(1);
            sv <= 1'b0;
            tick(2);
            @(negedge clk);
            chk({16'h0, cpo}, mix(a, g1, g2));
            @(posedge clk);
        end
        $display("monitor gain test done");
        wr(8'h80, 8'h02, RESP_OKAY);
        want <= 8'hF0;
        tick(6);
        rd(8'h4C, 8'h07, RESP_OKAY);
        wr(8'h4C, 8'h00, RESP_OKAY);
        rd(8'h4C, 8'h07, RESP_OKAY);
        want <= 8'hB8;
        tick(6);
        rd(8'h4C, 8'h01, RESP_OKAY);
        want <= 8'h00;
        tick(6);
        rd(8'h4C, 8'h00, RESP_OKAY);
        rd(8'h84, 8'h01, RESP_OKAY);
        rd(8'h88, 8'h07, RESP_OKAY);
        chk(irq, 1'b0);
        wr(8'h8C, 8'h07, RESP_OKAY);
        tick(2);
        chk(irq, 1'b1);
        wr(8'h84, 8'h00, RESP_OKAY);
        rd(8'h84, 8'h00, RESP_OKAY);
        wr(8'h88, 8'h06, RESP_OKAY);
        rd(8'h88, 8'h00, RESP_OKAY);
        wr(8'h8C, 8'h00, RESP_OKAY);
        tick(2);
        chk(irq, 1'b0);
        $display("fault and interrupt test done");
        for (int k = 0; k < 6; k++) begin
            e = rt[k];
            wr(8'h48, {6'h0, e[10], 1'b0}, RESP_OKAY);
            wr(8'h80, {7'h0, e[9]}, RESP_OKAY);
            want <= e[8:1];
            tick(6);
            chk(ring, e[0]);
            want <= 8'h00;
            tick(14);
            chk(ring, 1'b0);
        end
        $display("ring detect test done");
        report_and_stop();
    end
endmodule // test_line_side_ctrl_status_regs
